// *** design/plcr_top.sv ***
// Purpose : Control and routing side of four clock loops: pin selection, lock tracking,
//           post-scale counters, global net routing, external and converter clock outputs
// Assumes : One 125 MHz clock; loop clocks are modelled as divided toggles of it
// Notes   : Registers over a plain strobe port, read data one cycle after the read strobe
// Function
// - Pin pairs 0-1, 2-3, 4-5, 6-7 reach only loops 1/3, 2/4, 2/3, 1/4.
// - Each post counter reaches only its fixed four global clock nets.
// - Detector enable gates the detector; disabled loop drifts and may lose lock.
// - Detector is enabled after reset unless software disables it.
// - Loop reset clears counters, output clocks and lock.
// - Loop reset returns oscillator to nominal and stops it; an unused loop stops it too.
// - After reset release the loop resynchronizes to its reference and relocks.
// - Lock rises only once locked and outputs run at configured rate.
// - Raw lock falls at reset release, on loss of lock or when unused; capture flop exists only if reset enabled.
// - Four feedback modes, each with divide, phase and duty support; the counters here only divide, with fixed equal halves and no phase control.
// - Full compensation only from dedicated pins, not from a global net.
// - Normal mode aligns internal clocks to the pin; external output lags.
// - Zero-delay mode aligns the external output with the input pin.
// - No-compensation mode aligns nothing; all outputs are shifted.
// - Source-synchronous mode keeps data and clock phase at input registers.
// - One external output per loop, driven directly only by counter zero.
// - Differential output second pin carries the inverted clock.
// - Unused external output pins act as general-purpose I/O.
// - Only counter zero of loops 1 and 3 drives the converter clock.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "plcr_params.svh"

module plcr_top (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [7:0]  clk_pin,
    input  wire logic [3:0]  cascade_clk,
    input  wire logic [3:0]  loop_reset,
    output logic      [19:0] global_clock_net,
    output logic      [7:0]  pad_out,
    output logic      [7:0]  pad_oe,
    input  wire logic [7:0]  pad_in,
    input  wire logic [7:0]  gpio_out,
    input  wire logic [7:0]  gpio_oe,
    output logic      [7:0]  gpio_in,
    output logic             converter_clk,
    output logic      [3:0]  lock,
    output logic      [3:0]  lock_raw
);

    // ****************************************
    // Register file
    // ****************************************
    logic [31:0] ctrl_r;
    logic [19:0] div_r [4];
    logic [29:0] netsel_r [4];
    logic [31:0] misc_r;
    logic [31:0] status_w;

    // Software writes; reset leaves every detector enabled and every loop in use
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= `PLCR_CTRL_RST;
            misc_r <= `PLCR_MISC_RST;
            for (int i = 0; i < 4; i++) begin
                div_r[i]    <= 20'h00000;
                netsel_r[i] <= 30'h00000000;
            end
        end else if (reg_wr) begin
            if (reg_addr == `PLCR_OFF_CTRL) begin
                ctrl_r <= reg_wdata;
            end
            if (reg_addr == `PLCR_OFF_MISC) begin
                misc_r <= {19'h00000, reg_wdata[12:0]};
            end
            for (int i = 0; i < 4; i++) begin
                if (reg_addr == `PLCR_OFF_DIV0 + 8'(4 * i)) begin
                    div_r[i] <= reg_wdata[19:0];
                end
                if (reg_addr == `PLCR_OFF_NETSEL0 + 8'(4 * i)) begin
                    netsel_r[i] <= reg_wdata[29:0];
                end
            end
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= 32'h00000000;
            if (reg_addr == `PLCR_OFF_CTRL) begin
                reg_rdata <= ctrl_r;
            end
            if (reg_addr == `PLCR_OFF_MISC) begin
                reg_rdata <= misc_r;
            end
            if (reg_addr == `PLCR_OFF_STATUS) begin
                reg_rdata <= status_w;
            end
            for (int i = 0; i < 4; i++) begin
                if (reg_addr == `PLCR_OFF_DIV0 + 8'(4 * i)) begin
                    reg_rdata <= {12'h000, div_r[i]};
                end
                if (reg_addr == `PLCR_OFF_NETSEL0 + 8'(4 * i)) begin
                    reg_rdata <= {2'h0, netsel_r[i]};
                end
            end
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [7:0] pin_s1_r;
    logic [7:0] pin_s2_r;
    logic [7:0] pin_s3_r;
    logic [3:0] cas_s1_r;
    logic [3:0] cas_s2_r;
    logic [3:0] cas_s3_r;
    logic [3:0] rst_s1_r;
    logic [3:0] rst_s2_r;
    logic [7:0] pad_s1_r;
    logic [7:0] pad_s2_r;

    // Everything from pins passes two flops; third flop feeds only the edge detect
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
            pin_s3_r <= 8'h00;
            cas_s1_r <= 4'h0;
            cas_s2_r <= 4'h0;
            cas_s3_r <= 4'h0;
            // Loop resets start asserted, so no loop runs before the pin level arrives
            rst_s1_r <= 4'hf;
            rst_s2_r <= 4'hf;
            pad_s1_r <= 8'h00;
            pad_s2_r <= 8'h00;
        end else begin
            pin_s1_r <= clk_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            cas_s1_r <= cascade_clk;
            cas_s2_r <= cas_s1_r;
            cas_s3_r <= cas_s2_r;
            rst_s1_r <= loop_reset;
            rst_s2_r <= rst_s1_r;
            pad_s1_r <= pad_in;
            pad_s2_r <= pad_s1_r;
        end
    end

    assign gpio_in = pad_s2_r;

    // Rising edges of every candidate reference
    logic [7:0] pin_rise;
    logic [3:0] cas_rise;
    assign pin_rise = pin_s2_r & ~pin_s3_r;
    assign cas_rise = cas_s2_r & ~cas_s3_r;

    // Pin index of a loop's four selectable pins: low select bit picks the pin, high bit the pair
    function automatic logic [2:0] pin_of(input logic [1:0] loop, input logic [1:0] sel);
        logic [2:0] base_a;
        logic [2:0] base_b;
        base_a = 3'h0;
        base_b = 3'h0;
        unique case (loop)
            2'h0: begin base_a = 3'h0; base_b = 3'h6; end
            2'h1: begin base_a = 3'h2; base_b = 3'h4; end
            2'h2: begin base_a = 3'h0; base_b = 3'h4; end
            2'h3: begin base_a = 3'h2; base_b = 3'h6; end
        endcase
        return (sel[1] ? base_b : base_a) + {2'h0, sel[0]};
    endfunction

    // Global nets each post counter may reach, indexed loop*5+counter
    function automatic logic [19:0] net_mask(input logic [4:0] src);
        unique case (src)
            5'h00: net_mask = 20'h48009;
            5'h01: net_mask = 20'h90012;
            5'h02: net_mask = 20'h28005;
            5'h03: net_mask = 20'h5000a;
            5'h04: net_mask = 20'ha0014;
            5'h05: net_mask = 20'h02520;
            5'h06: net_mask = 20'h04a40;
            5'h07: net_mask = 20'h014a0;
            5'h08: net_mask = 20'h02940;
            5'h09: net_mask = 20'h05280;
            5'h0a: net_mask = 20'h02409;
            5'h0b: net_mask = 20'h04812;
            5'h0c: net_mask = 20'h01405;
            5'h0d: net_mask = 20'h0280a;
            5'h0e: net_mask = 20'h05014;
            5'h0f: net_mask = 20'h48120;
            5'h10: net_mask = 20'h90240;
            5'h11: net_mask = 20'h280a0;
            5'h12: net_mask = 20'h50140;
            5'h13: net_mask = 20'ha0280;
            default: net_mask = 20'h00000;
        endcase
    endfunction

    // ****************************************
    // Per-loop lock tracking and post counters
    // ****************************************
    logic [19:0] post_clk;
    logic [3:0]  ext_src;
    logic [3:0]  compensated;
    logic [3:0]  osc_nominal;
    logic [3:0]  running;

    for (genvar l = 0; l < 4; l++) begin : g_loop
        plcr_pkg::plcr_state_t state_r;
        logic [3:0]  edge_cnt_r;
        logic [5:0]  trim_r;
        logic        raw_r;
        logic        cap_r;
        logic        align_r;
        logic [7:0]  cfg;
        logic        rst_any;
        logic        ref_rise;
        logic        det_en;
        logic        used;
        logic [2:0]  pin_idx;
        plcr_pkg::plcr_mode_t mode;

        assign cfg      = ctrl_r[8*l +: 8];
        assign used     = cfg[`PLCR_CTRL_USED];
        assign det_en   = cfg[`PLCR_CTRL_DET_EN];
        assign mode     = plcr_pkg::plcr_mode_t'(cfg[`PLCR_CTRL_MODE +: 2]);
        assign rst_any  = rst_s2_r[l] | cfg[`PLCR_CTRL_RESET];
        assign pin_idx  = pin_of(2'(l), misc_r[2*l +: 2]);
        // A loop fed from a global net loses full compensation
        assign ref_rise = cfg[`PLCR_CTRL_GLOB] ? cas_rise[l] : pin_rise[pin_idx];
        assign compensated[l] = ~cfg[`PLCR_CTRL_GLOB] & (mode != plcr_pkg::PLCR_MODE_NOCOMP);
        assign osc_nominal[l] = (trim_r == `PLCR_TRIM_NOM);
        assign running[l]     = used & ~rst_any;

        // Lock state: hold in reset, count reference edges, then watch for drift
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                state_r    <= plcr_pkg::PLCR_ST_HOLD;
                edge_cnt_r <= 4'h0;
                trim_r     <= `PLCR_TRIM_NOM;
                align_r    <= 1'b0;
            end else begin
                align_r <= 1'b0;
                if (rst_any || !used) begin
                    state_r    <= plcr_pkg::PLCR_ST_HOLD;
                    edge_cnt_r <= 4'h0;
                    trim_r     <= `PLCR_TRIM_NOM;
                end else begin
                    unique case (state_r)
                        plcr_pkg::PLCR_ST_HOLD: begin
                            state_r <= plcr_pkg::PLCR_ST_ACQUIRE;
                        end
                        plcr_pkg::PLCR_ST_ACQUIRE: begin
                            // A gated detector makes no progress toward lock
                            if (ref_rise && det_en) begin
                                edge_cnt_r <= edge_cnt_r + 4'h1;
                                if (edge_cnt_r == `PLCR_LOCK_EDGES - 4'h1) begin
                                    state_r <= plcr_pkg::PLCR_ST_LOCKED;
                                    align_r <= 1'b1;
                                end
                            end
                        end
                        plcr_pkg::PLCR_ST_LOCKED: begin
                            if (det_en) begin
                                trim_r <= `PLCR_TRIM_NOM;
                            end else if (ref_rise) begin
                                // Holding last frequency, error grows per reference edge
                                trim_r <= trim_r + 6'h01;
                                if (trim_r == `PLCR_TRIM_NOM + `PLCR_DRIFT_LIMIT - 6'h01) begin
                                    state_r    <= plcr_pkg::PLCR_ST_ACQUIRE;
                                    edge_cnt_r <= 4'h0;
                                end
                            end
                        end
                        default: begin
                            state_r <= plcr_pkg::PLCR_ST_HOLD;
                        end
                    endcase
                end
            end
        end

        // Raw lock keeps its value through reset and falls at the release
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                raw_r <= 1'b0;
            end else if (state_r == plcr_pkg::PLCR_ST_HOLD && !rst_any) begin
                raw_r <= 1'b0;
            end else if (!rst_any) begin
                raw_r <= (state_r == plcr_pkg::PLCR_ST_LOCKED);
            end
        end

        // Capture flop clears at once while reset is held
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                cap_r <= 1'b0;
            end else begin
                cap_r <= raw_r & ~rst_any & (state_r == plcr_pkg::PLCR_ST_LOCKED);
            end
        end

        // Without reset in use the capture stage is bypassed
        assign lock[l]     = misc_r[`PLCR_MISC_RST_EN + l] ? cap_r : raw_r;
        assign lock_raw[l] = raw_r;

        // Post-scale counters: half period is divide value plus one cycles
        for (genvar c = 0; c < 5; c++) begin : g_post
            logic [3:0] cnt_r;
            logic       out_r;
            logic [3:0] div;
            logic       realign;
            assign div = div_r[l][4*c +: 4];
            // Normal and source-sync realign internals; zero-delay realigns counter zero only
            assign realign = align_r & ((mode == plcr_pkg::PLCR_MODE_NORMAL)
                                      | (mode == plcr_pkg::PLCR_MODE_SRCSYNC)
                                      | ((mode == plcr_pkg::PLCR_MODE_ZDB) && c == 0));

            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    cnt_r <= 4'h0;
                    out_r <= 1'b0;
                end else if (!running[l]) begin
                    cnt_r <= 4'h0;
                    out_r <= 1'b0;
                end else if (realign) begin
                    // Zero-delay starts one count ahead to cover the pad register
                    cnt_r <= (mode == plcr_pkg::PLCR_MODE_ZDB) ? 4'h1 : 4'h0;
                    out_r <= 1'b1;
                end else if (cnt_r >= div) begin
                    cnt_r <= 4'h0;
                    out_r <= ~out_r;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
            assign post_clk[5*l + c] = out_r;
        end

        assign ext_src[l] = post_clk[5*l];
    end

    // ****************************************
    // Global net routing
    // ****************************************
    // Each net takes its selected counter only if the fixed wiring allows it
    for (genvar n = 0; n < 20; n++) begin : g_net
        logic [5:0]  sel;
        logic [19:0] mask;
        assign sel  = netsel_r[n / 5][6*(n % 5) +: 6];
        assign mask = net_mask(sel[4:0]);
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                global_clock_net[n] <= 1'b0;
            end else begin
                global_clock_net[n] <= sel[5] & mask[n] & post_clk[sel[4:0]];
            end
        end
    end

    // ****************************************
    // External outputs and converter clock
    // ****************************************
    // Pad register adds the lag that the normal mode shows at the pin
    for (genvar l = 0; l < 4; l++) begin : g_ext
        logic ext_en;
        logic diff;
        assign ext_en = ctrl_r[8*l + `PLCR_CTRL_EXT_EN];
        assign diff   = ctrl_r[8*l + `PLCR_CTRL_DIFF];
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                pad_out[2*l]     <= 1'b0;
                pad_out[2*l + 1] <= 1'b0;
                pad_oe[2*l]      <= 1'b0;
                pad_oe[2*l + 1]  <= 1'b0;
            end else if (ext_en) begin
                pad_out[2*l]     <= ext_src[l];
                pad_out[2*l + 1] <= diff ? ~ext_src[l] : gpio_out[2*l + 1];
                pad_oe[2*l]      <= 1'b1;
                pad_oe[2*l + 1]  <= diff | gpio_oe[2*l + 1];
            end else begin
                pad_out[2*l]     <= gpio_out[2*l];
                pad_out[2*l + 1] <= gpio_out[2*l + 1];
                pad_oe[2*l]      <= gpio_oe[2*l];
                pad_oe[2*l + 1]  <= gpio_oe[2*l + 1];
            end
        end
    end

    // Dedicated converter path: loop 1 or loop 3 counter zero, nothing else
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            converter_clk <= 1'b0;
        end else begin
            converter_clk <= misc_r[`PLCR_MISC_CONV] ? ext_src[2] : ext_src[0];
        end
    end

    // ****************************************
    // Status word
    // ****************************************
    assign status_w = {12'h000, running, osc_nominal, compensated, lock_raw, lock};

endmodule

// *** design/plcr_params.svh ***
// Purpose : Offsets, field positions, reset values and counts for the loop control block
// Assumes : Included by bare name from the top module
// Notes   : Word registers, byte offsets, 32-bit data
`ifndef PLCR_PARAMS_SVH
`define PLCR_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PLCR_OFF_CTRL     8'h00
`define PLCR_OFF_DIV0     8'h04
`define PLCR_OFF_NETSEL0  8'h14
`define PLCR_OFF_MISC     8'h24
`define PLCR_OFF_STATUS   8'h28

// ****************************************
// Field positions
// ****************************************
`define PLCR_CTRL_USED    0
`define PLCR_CTRL_DET_EN  1
`define PLCR_CTRL_RESET   2
`define PLCR_CTRL_GLOB    3
`define PLCR_CTRL_MODE    4
`define PLCR_CTRL_EXT_EN  6
`define PLCR_CTRL_DIFF    7
`define PLCR_MISC_RST_EN  8
`define PLCR_MISC_CONV    12

// ****************************************
// Reset values and counts
// ****************************************
`define PLCR_CTRL_RST     32'h03030303
`define PLCR_MISC_RST     32'h00000f00
`define PLCR_LOCK_EDGES   4'h8
`define PLCR_TRIM_NOM     6'h20
`define PLCR_DRIFT_LIMIT  6'h10

`endif

// *** design/plcr_pkg.sv ***
// Purpose : Types shared by the loop control block
// Assumes : Nothing beyond the params header
// Notes   : Numeric constants live in the header as macros
package plcr_pkg;

    // Feedback compensation modes
    typedef enum logic [1:0] {
        PLCR_MODE_NORMAL  = 2'b00,
        PLCR_MODE_ZDB     = 2'b01,
        PLCR_MODE_NOCOMP  = 2'b10,
        PLCR_MODE_SRCSYNC = 2'b11
    } plcr_mode_t;

    // Per-loop lock tracking states
    typedef enum logic [1:0] {
        PLCR_ST_HOLD    = 2'b00,
        PLCR_ST_ACQUIRE = 2'b01,
        PLCR_ST_LOCKED  = 2'b10
    } plcr_state_t;

endpackage

// *** tb/plcr_asserts.sv ***
// Purpose: Port checks of the loop control block
// Assumes: Reset-enable bits at their defaults
// Notes: Loop 0 stands in for the per-loop timing
`timescale 1ns/10ps
module plcr_checker (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [3:0]  loop_reset,
    input wire logic [19:0] global_clock_net,
    input wire logic        converter_clk,
    input wire logic [7:0]  pad_in,
    input wire logic [7:0]  gpio_in,
    input wire logic [3:0]  lock,
    input wire logic [3:0]  lock_raw
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Read data may only stand in the slot after a read
    rd_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("stray read data");
    lock_raw_a: assert property (lock[0] |-> $past(lock_raw[0]))
        else $error("lock before raw lock");
    reset_lock_a: assert property (loop_reset[0] [*5] |-> !lock[0])
        else $error("lock kept in reset");
    reset_quiet_a: assert property ((&loop_reset) [*6] |-> global_clock_net == 20'h0 && !converter_clk)
        else $error("clock out in reset");
    raw_hold_a: assert property (loop_reset[0] [*4] |-> $stable(lock_raw[0]))
        else $error("raw lock moved in reset");
    // Eight reference edges cannot fit in fewer than eight cycles
    relock_gap_a: assert property ($fell(loop_reset[0]) |-> ##5 (!lock_raw[0]) [*8])
        else $error("relock too early");
    relock_in_a: assert property ($fell(loop_reset[0]) |-> ##[12:400] lock[0])
        else $error("no relock");
    gpio_in_a: assert property (($past(reset_n, 4) && pad_in == $past(pad_in)) [*4] |-> gpio_in == pad_in)
        else $error("pad level lost");
    cover property ($rose(lock[0]));
    cover property ($fell(lock[1]) && !loop_reset[1]);
    cover property ($fell(loop_reset[0]));
endmodule
bind plcr_top plcr_checker chk_u (.clock, .reset_n, .reg_rd, .reg_rdata, .loop_reset, .global_clock_net,
    .converter_clk, .pad_in, .gpio_in, .lock, .lock_raw);

// *** tb/plcr_fabric.sv ***
// Purpose: Fabric user logic beside the loop control block
// Assumes: Reference clocks run free at a quarter of the system rate
// Notes: Stopped pins sit low, as a dead oscillator would
`timescale 1ns/10ps
module plcr_fabric (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic [3:0] rst_req,
    input  wire logic [7:0] pin_run,
    input  wire logic [3:0] lock,
    output logic      [7:0] clk_pin,
    output logic      [3:0] cascade_clk,
    output logic      [3:0] loop_reset,
    output logic      [3:0] hold_user
);
    // ****
    // Reference clocks and loop control
    // ****
    logic [1:0] div_r;
    // Loops stay in reset until the user releases them
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_r       <= 2'h0;
            clk_pin     <= 8'h00;
            cascade_clk <= 4'h0;
            loop_reset  <= 4'hf;
            hold_user   <= 4'hf;
        end else begin
            div_r       <= div_r + 2'h1;
            clk_pin     <= {8{div_r[1]}} & pin_run;
            cascade_clk <= {4{div_r[1]}};
            loop_reset  <= rst_req;
            hold_user   <= ~lock;
        end
    end
endmodule

// *** tb/testbench.sv ***
// Purpose: Self-checking bench of the loop control block
// Assumes: Reset-enable bits stay at their defaults
// Notes: Reads are scored one cycle later from a queue
`timescale 1ns/10ps
module testbench;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        rd_d = 1'b0;
    logic [3:0]  rst_req = 4'hf;
    logic [7:0]  pin_run = 8'hff;
    logic [7:0]  pad_in = 8'h00;
    logic [31:0] seed = 32'h2;
    logic [63:0] exp_q[$];
    logic [63:0] e;
    int          num_errors = 0;
    int          checks_done = 0;
    wire  [31:0] reg_rdata;
    wire  [19:0] nets;
    wire  [7:0]  clk_pin, pad_out, pad_oe, gpio_in;
    wire  [3:0]  cascade_clk, loop_reset, lock, lock_raw;
    wire         converter_clk;
    // ****
    // Design and fabric
    // ****
    always #4 clock = ~clock;
    plcr_top dut_u (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .clk_pin,
        .cascade_clk, .loop_reset, .global_clock_net(nets), .pad_out, .pad_oe, .pad_in,
        .gpio_out(8'ha5), .gpio_oe(8'hc3), .gpio_in, .converter_clk, .lock, .lock_raw);
    plcr_fabric fab_u (.clock, .reset_n, .rst_req, .pin_run, .lock, .clk_pin, .cascade_clk,
        .loop_reset, .hold_user());
    // ****
    // Tasks
    // ****
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
            num_errors++;
        end
    endtask
    // A spare cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        exp_q.push_back({m, v});
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
    endtask
    task automatic settle(input int l, input logic v, input logic want);
        int n;
        n = 0;
        while (lock[l] !== v && n < 600) begin
            @(posedge clock);
            n++;
        end
        cmp(32'(lock[l]), 32'(want));
    endtask
    task automatic finish_test();
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Score each read in the cycle after its strobe
    always @(posedge clock) begin
        rd_d <= reg_rd;
        if (rd_d) begin
            e = exp_q.pop_front();
            cmp(reg_rdata & e[63:32], e[31:0]);
        end
    end
    always begin
        repeat (8) @(posedge clock);
        pad_in <= 8'(xorshift());
    end
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        finish_test();
    end
    // ****
    // Scenarios
    // ****
    initial begin
        logic [31:0] d;
        int n;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rd(8'h00, '1, 32'h03030303);
        rd(8'h24, '1, 32'h00000f00);
        rd(8'h30, '1, 32'h0);
        d = xorshift() & 32'h000fffff;
        wr(8'h08, d);
        rd(8'h08, 32'h000fffff, d);
        rd(8'h28, 32'h000fff0f, 32'h0000ff00);
        rst_req <= 4'h0;
        for (int l = 0; l < 4; l++) settle(l, 1'b1, 1'b1);
        rd(8'h28, 32'hff, 32'hff);
        for (int m = 0; m < 4; m++) begin
            wr(8'h00, 32'h03030303 | (32'(m) << 4));
            rst_req <= 4'h1;
            repeat (6) @(posedge clock);
            cmp(32'(lock[0]), 32'h0);
            rd(8'h28, 32'h00011101, 32'h00001000 | (32'(m != 2) << 8));
            rst_req <= 4'h0;
            settle(0, 1'b1, 1'b1);
        end
        wr(8'h00, 32'h03030103);
        settle(1, 1'b0, 1'b0);
        cmp(32'(lock[0]), 32'h1);
        wr(8'h00, 32'h03030303);
        settle(1, 1'b1, 1'b1);
        // Loop 2 on a global net loses compensation; unused loop 4 stops at nominal
        wr(8'h00, 32'h00030b03);
        rd(8'h28, 32'h000a8200, 32'h00028000);
        wr(8'h00, 32'h03030303);
        settle(3, 1'b1, 1'b1);
        // Loop 3 on pin 4 must not lock from a live pin 0
        wr(8'h24, 32'h00000f20);
        pin_run <= 8'hcf;
        rst_req <= 4'h4;
        repeat (8) @(posedge clock);
        rst_req <= 4'h0;
        settle(2, 1'b1, 1'b0);
        pin_run <= 8'hff;
        settle(2, 1'b1, 1'b1);
        wr(8'h14, 32'h00000820);
        wr(8'h00, 32'h030303c3);
        repeat (4) @(posedge clock);
        n = 0;
        repeat (16) begin
            @(posedge clock);
            n += int'(converter_clk) + int'(nets[0]);
            cmp(32'(nets[1]), 32'h0);
            cmp(32'({pad_oe[1:0], pad_out[1] ^ pad_out[0]}), 32'h7);
            cmp(32'({pad_oe[7:6], pad_out[7:6]}), 32'he);
        end
        cmp(32'(n > 0), 32'h1);
        // Converter from loop 3 keeps running while loop 1 sits in reset
        wr(8'h24, 32'h00001f20);
        rst_req <= 4'h1;
        repeat (6) @(posedge clock);
        n = 0;
        repeat (8) begin
            @(posedge clock);
            n += int'(converter_clk);
            cmp(32'({nets[0], pad_out[0]}), 32'h0);
        end
        cmp(32'(n > 0), 32'h1);
        finish_test();
    end
endmodule
